// [rtl/fpsab_unit.sv]
// Register-stack datapath for add, absolute value, 2^x-1 and decimal load.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - exp op writes 2^x minus one to head, but leaves power-of-two sources as they are
// - exp flags underflow, invalid, denormal, stack, inexact
// - absolute value clears only the sign bit
// - absolute value always clears condition code one
// - absent or swap flag gives unavailable fault unless the low disable bit is set
// - add writes a stack register; four memory formats
// - three add forms: pop, memory, register pair
// - popping add empties head, index plus one
// - integer source converted to extended before adding
// - exact cancel gives plus zero, minus rounding down
// - like infinities keep sign; unlike ones invalid
// - decimal load pushes exact signed conversion
// - decimal digits above nine are not checked
// - decimal push onto full slot is stack fault
// - low disable bit gives disabled register fault
module fpsab_unit
    import fpsab_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire fpsab_op_t i_op,
    input wire fpsab_form_t i_form,
    input wire logic [2:0] i_sti_idx,
    input wire logic [79:0] i_mem_data,
    input wire fpsab_fmt_t i_mem_fmt,
    input wire logic [1:0] i_round_mode,
    input wire logic i_fpu_absent_flag,
    input wire logic i_context_swap_flag,
    input wire logic i_low_fp_disable_bit,
    input wire logic i_clear_flags,
    output logic o_done,
    output logic o_device_unavailable_fault,
    output logic o_disabled_fp_reg_fault,
    output logic o_stack_fault_exc,
    output logic o_invalid_operand_exc,
    output logic o_cond_code_one,
    output logic [79:0] o_stack_head_reg,
    output logic [2:0] o_top,
    output logic [7:0] o_tag,
    output logic [4:0] o_sticky_flags
);

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------

    // Normalises m * 2^(e - bias - 66) into extended real.
    // Returns {inexact, underflow, denormal, value}; truncation only.
    function automatic logic [82:0] pack(input logic sgn,
            input logic [67:0] m, input logic signed [19:0] e);
        int pos;
        int sh;
        logic signed [19:0] ee;
        logic [67:0] nm;
        logic [127:0] wide;
        logic lost;
        pos = 0;
        for (int i = 0; i < 68; i++) begin
            if (m[i]) pos = i;
        end
        nm = m << (67 - pos);
        ee = e + 20'(pos) - 20'(WORK_MSB);
        lost = |nm[3:0];
        pack = {lost, 2'b00, sgn, ee[14:0], nm[67:4]};
        if (m == 68'h0) begin
            pack = {3'b000, sgn, 79'h0};
        end else if (ee >= EXP_TOP) begin
            pack = {1'b1, 2'b00, sgn, EXP_ALL_ONES, 1'b1, 63'h0};
        end else if (ee <= 20'sh0) begin
            sh = 1 - int'(ee);
            if (sh > 64) sh = 64;
            wide = {nm[67:4], 64'h0} >> sh;
            lost = lost | (|wide[63:0]);
            pack = {lost, lost, 1'b1, sgn, 15'h0, wide[127:64]};
        end
    endfunction : pack

    function automatic logic is_nan(input logic [79:0] v);
        is_nan = (v[78:64] == EXP_ALL_ONES) && (v[62:0] != 63'h0);
    endfunction : is_nan

    // Signalling NaN or an encoding with the integer bit missing.
    function automatic logic is_bad(input logic [79:0] v);
        is_bad = (is_nan(v) && !v[62]) || (v[78:64] != 15'h0 && !v[63]);
    endfunction : is_bad

    function automatic logic is_inf(input logic [79:0] v);
        is_inf = (v[78:64] == EXP_ALL_ONES) && (v[62:0] == 63'h0);
    endfunction : is_inf

    // Memory operand to extended real; integers are exact.
    function automatic logic [79:0] from_mem(input logic [79:0] d,
            input fpsab_fmt_t f);
        logic [31:0] iv;
        logic [31:0] mag;
        logic [82:0] p;
        iv = (f == FMT_INT16) ? {{16{d[15]}}, d[15:0]} : d[31:0];
        mag = iv[31] ? 32'(-iv) : iv;
        p = pack(iv[31], {1'b0, mag, 35'h0}, EXP_BIAS + INT_POINT);
        if (f == FMT_SINGLE) begin
            if (d[30:23] == 8'hFF)
                p = {3'b000, d[31], EXP_ALL_ONES, 1'b1, d[22:0], 40'h0};
            else
                p = pack(d[31], {1'b0, d[30:23] != 8'h0, d[22:0], 43'h0},
                    EXP_BIAS - SINGLE_BIAS
                    + 20'(d[30:23] == 8'h0 ? 8'h1 : d[30:23]));
        end else if (f == FMT_DOUBLE) begin
            if (d[62:52] == 11'h7FF)
                p = {3'b000, d[63], EXP_ALL_ONES, 1'b1, d[51:0], 11'h0};
            else
                p = pack(d[63], {1'b0, d[62:52] != 11'h0, d[51:0], 14'h0},
                    EXP_BIAS - DOUBLE_BIAS
                    + 20'(d[62:52] == 11'h0 ? 11'h1 : d[62:52]));
        end
        from_mem = p[79:0];
    endfunction : from_mem

    // Adder; returns {invalid, inexact, underflow, denormal, value}.
    function automatic logic [83:0] add(input logic [79:0] a,
            input logic [79:0] b, input logic [1:0] rm);
        logic [79:0] x;
        logic [79:0] y;
        logic [19:0] ex;
        logic [19:0] ey;
        logic [135:0] sy;
        logic [67:0] m;
        logic [82:0] p;
        add = {1'b0, 3'b000, a};
        if (is_bad(a) || is_bad(b)) begin
            add = {1'b1, 3'b000, QNAN_INDEFINITE};
        end else if (is_nan(a)) begin
            add = {1'b0, 3'b000, a};
        end else if (is_nan(b)) begin
            add = {1'b0, 3'b000, b};
        end else if (is_inf(a) && is_inf(b)) begin
            if (a[79] != b[79])
                add = {1'b1, 3'b000, QNAN_INDEFINITE};
        end else if (is_inf(b)) begin
            add = {1'b0, 3'b000, b};
        end else if (!is_inf(a)) begin
            x = (a[78:0] < b[78:0]) ? b : a;
            y = (a[78:0] < b[78:0]) ? a : b;
            ex = 20'(x[78:64] == 15'h0 ? 15'h1 : x[78:64]);
            ey = 20'(y[78:64] == 15'h0 ? 15'h1 : y[78:64]);
            sy = {1'b0, y[63:0], 3'b000, 68'h0} >> (ex - ey);
            if (x[79] == y[79])
                m = {1'b0, x[63:0], 3'b000} + sy[135:68];
            else
                m = {1'b0, x[63:0], 3'b000} - sy[135:68];
            m[0] = m[0] | (|sy[67:0]);
            p = pack(x[79], m, ex);
            add = {1'b0, p};
            // Exact cancellation picks its sign from the rounding mode.
            if (m == 68'h0 && x[79] != y[79])
                add = {4'b0000, rm == RC_DOWN, 79'h0};
        end
    endfunction : add

    // Signed Q2.62 product.
    function automatic logic [63:0] mulq(input logic [63:0] a,
            input logic [63:0] b);
        logic signed [127:0] pr;
        pr = $signed({{64{a[63]}}, a}) * $signed({{64{b[63]}}, b});
        mulq = pr[125:62];
    endfunction : mulq

    // ------------------------------------------------------------------
    // Stack state, flags and registered outputs
    // ------------------------------------------------------------------
    logic [79:0] stack_reg [0:7];
    logic [79:0] next_stack_reg [0:7];
    logic [7:0] tag;
    logic [7:0] next_tag;
    logic [2:0] top;
    logic [2:0] next_top;
    logic [4:0] flags;     // {stack, invalid, denormal, underflow, inexact}
    logic [4:0] next_flags;
    logic next_done, next_dna, next_dis, next_sfx, next_iax, next_cc1, cc1;
    logic [79:0] next_head;

    // Scratch values of the operation in flight.
    logic [2:0] pd;
    logic [79:0] sa;
    logic [79:0] sb;
    logic use_b, pop;
    logic [83:0] sum;
    logic [82:0] res;
    logic [63:0] fx;
    logic [63:0] acc;
    logic [59:0] bcd;

    // One operation per valid cycle; every fault keeps the stack intact.
    always_comb begin
        next_stack_reg = stack_reg;
        next_tag = tag;
        next_top = top;
        next_flags = i_clear_flags ? 5'h00 : flags;
        next_done = i_op_valid;
        next_dna = 1'b0;
        next_dis = 1'b0;
        next_sfx = 1'b0;
        next_iax = 1'b0;
        next_cc1 = cc1;
        pd = top;
        sa = stack_reg[top];
        sb = stack_reg[3'(top + i_sti_idx)];
        use_b = 1'b1;
        pop = 1'b0;
        sum = 84'h0;
        res = 83'h0;
        fx = 64'h0;
        acc = Q62_ONE;
        bcd = 60'h0;
        if (i_op_valid) begin
            if (i_low_fp_disable_bit) begin
                next_dis = 1'b1;
            end else if (i_fpu_absent_flag || i_context_swap_flag) begin
                next_dna = 1'b1;
            end else begin
                unique case (i_op)
                    FLOAT_ADD_OP, FLOAT_ADD_POP_OP,
                    INTEGER_SOURCE_ADD_OP: begin
                        // Pick operands and destination by form.
                        if (i_op == FLOAT_ADD_POP_OP) begin
                            pd = 3'(top + i_sti_idx);
                            pop = 1'b1;
                        end else if (i_op == INTEGER_SOURCE_ADD_OP ||
                                i_form == FORM_MEMORY) begin
                            sb = from_mem(i_mem_data, i_mem_fmt);
                            use_b = 1'b0;
                        end else if (i_form == FORM_NO_OPERAND) begin
                            sb = stack_reg[3'(top + 3'h1)];
                            pd = 3'(top + 3'h1);
                            pop = 1'b1;
                        end else if (i_form == FORM_INDEXED_DEST) begin
                            pd = 3'(top + i_sti_idx);
                        end
                        if (!tag[top] || (use_b && !tag[pd])) begin
                            next_sfx = 1'b1;
                            next_cc1 = 1'b0;
                        end else begin
                            sum = add(sa, sb, i_round_mode);
                            next_stack_reg[pd] = sum[79:0];
                            next_iax = sum[83];
                            // Adder order is {invalid, inexact, under, denorm}.
                            next_flags[3:0] = next_flags[3:0] | {sum[83],
                                sum[80], sum[81], sum[82]};
                            if (pop) begin
                                next_tag[top] = 1'b0;
                                next_top = 3'(top + 3'h1);
                            end
                        end
                    end
                    EXP2_MINUS_ONE_OP: begin
                        if (!tag[top]) begin
                            next_sfx = 1'b1;
                        end else if (is_bad(sa)) begin
                            next_iax = 1'b1;
                            next_flags[3] = 1'b1;
                            next_stack_reg[top] = QNAN_INDEFINITE;
                        end else if (is_inf(sa) && sa[79]) begin
                            next_stack_reg[top] = NEG_ONE;
                        end else if (!is_nan(sa) && !is_inf(sa) &&
                                sa[62:0] != 63'h0) begin
                            // Tiny sources shift out to zero; wide ones are
                            // undefined anyway.
                            fx = sa[63:0] >> (EXP_FIX_LIMIT - sa[78:64]);
                            fx = mulq(sa[79] ? 64'(-fx) : fx, Q62_LN2);
                            // Horner series of e^f - 1 with f = x ln2.
                            for (int k = EXP_TERMS; k >= 2; k--) begin
                                acc = Q62_ONE + mulq(mulq(fx, acc),
                                    64'(Q62_ONE / 64'(k)));
                            end
                            acc = mulq(fx, acc);
                            res = pack(acc[63], {4'h0,
                                acc[63] ? 64'(-acc) : acc},
                                EXP_BIAS + FIX_POINT);
                            next_stack_reg[top] = res[79:0];
                            next_flags[2:0] = next_flags[2:0]
                                | {res[80], res[81], 1'b1};
                        end
                    end
                    ABSOLUTE_VALUE_OP: begin
                        next_cc1 = 1'b0;
                        if (!tag[top]) begin
                            next_sfx = 1'b1;
                        end else begin
                            next_stack_reg[top][79] = 1'b0;
                        end
                    end
                    DECIMAL_LOAD_PUSH_OP: begin
                        if (tag[3'(top - 3'h1)]) begin
                            next_sfx = 1'b1;
                            next_cc1 = 1'b1;
                        end else begin
                            // Digits above nine are summed as is.
                            for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
                                bcd = 60'(bcd * 60'd10)
                                    + 60'(i_mem_data[4*d +: 4]);
                            end
                            res = pack(i_mem_data[79], {1'b0, bcd, 7'h0},
                                EXP_BIAS + BCD_POINT);
                            next_top = 3'(top - 3'h1);
                            next_stack_reg[next_top] = res[79:0];
                            next_tag[next_top] = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        next_iax = next_iax | next_sfx;
        if (next_sfx) next_flags[4:3] = 2'b11;
        next_head = next_stack_reg[next_top];
    end

    // Registers only; set of a flag wins over a same-cycle clear.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            for (int r = 0; r < 8; r++) begin
                stack_reg[r] <= RESET_REG;
            end
            tag <= RESET_TAG;
            top <= RESET_TOP;
            flags <= 5'h00;
            cc1 <= 1'b0;
            o_done <= 1'b0;
            o_device_unavailable_fault <= 1'b0;
            o_disabled_fp_reg_fault <= 1'b0;
            o_stack_fault_exc <= 1'b0;
            o_invalid_operand_exc <= 1'b0;
            o_stack_head_reg <= RESET_REG;
        end else begin
            stack_reg <= next_stack_reg;
            tag <= next_tag;
            top <= next_top;
            flags <= next_flags;
            cc1 <= next_cc1;
            o_done <= next_done;
            o_device_unavailable_fault <= next_dna;
            o_disabled_fp_reg_fault <= next_dis;
            o_stack_fault_exc <= next_sfx;
            o_invalid_operand_exc <= next_iax;
            o_stack_head_reg <= next_head;
        end
    end

    // These mirror flip-flops directly.
    assign o_top = top;
    assign o_tag = tag;
    assign o_sticky_flags = flags;
    assign o_cond_code_one = cc1;

endmodule : fpsab_unit
`default_nettype wire

// [rtl/fpsab_pkg.sv]
// Shared types and constants of the floating-point stack arithmetic slice.
package fpsab_pkg;

    // ------------------------------------------------------------------
    // Operations, add forms, memory formats and rounding modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FLOAT_ADD_OP,
        FLOAT_ADD_POP_OP,
        INTEGER_SOURCE_ADD_OP,
        EXP2_MINUS_ONE_OP,
        ABSOLUTE_VALUE_OP,
        DECIMAL_LOAD_PUSH_OP
    } fpsab_op_t;

    typedef enum logic [1:0] {
        FORM_NO_OPERAND,
        FORM_MEMORY,
        FORM_HEAD_DEST,
        FORM_INDEXED_DEST
    } fpsab_form_t;

    typedef enum logic [1:0] {
        FMT_SINGLE,
        FMT_DOUBLE,
        FMT_INT16,
        FMT_INT32
    } fpsab_fmt_t;

    localparam logic [1:0] RC_DOWN = 2'h1;

    // ------------------------------------------------------------------
    // Number formats and working-point constants
    // ------------------------------------------------------------------
    localparam logic signed [19:0] EXP_BIAS = 20'sh03FFF;
    localparam logic signed [19:0] EXP_TOP = 20'sh07FFF;
    localparam logic [14:0] EXP_ALL_ONES = 15'h7FFF;
    localparam logic signed [19:0] SINGLE_BIAS = 20'sh0007F;
    localparam logic signed [19:0] DOUBLE_BIAS = 20'sh003FF;
    localparam logic signed [19:0] INT_POINT = 20'sh0001F;
    localparam logic signed [19:0] BCD_POINT = 20'sh0003B;
    localparam logic signed [19:0] FIX_POINT = 20'sh00004;
    localparam int WORK_MSB = 66;
    localparam int BCD_DIGITS = 18;
    localparam int EXP_TERMS = 12;
    localparam logic [79:0] QNAN_INDEFINITE = 80'hFFFF_C000_0000_0000_0000;
    localparam logic [79:0] NEG_ONE = 80'hBFFF_8000_0000_0000_0000;
    localparam logic [63:0] Q62_ONE = 64'h4000_0000_0000_0000;
    localparam logic [63:0] Q62_LN2 = 64'h2C5C_85FD_F473_DE6A;
    localparam logic [14:0] EXP_FIX_LIMIT = 15'h4000;
    localparam logic [79:0] RESET_REG = 80'h0;
    localparam logic [2:0] RESET_TOP = 3'h0;
    localparam logic [7:0] RESET_TAG = 8'h00;

endpackage : fpsab_pkg

// [sim/fpsab_issue_model.sv]
// Behavioural model of the decode and operand fetch logic feeding the slice.
`timescale 1ns/1ps
`default_nettype none
module fpsab_issue_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic [79:0] i_data,
    output logic o_op_valid,
    output logic [79:0] o_mem_data
);
    // ------------------------------------------------------------------
    // Operand bus
    // ------------------------------------------------------------------
    logic [79:0] last_data;

    // Keep the last word so a released bus can show its inverse.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            last_data <= 80'h0;
        end else if (i_req) begin
            last_data <= i_data;
        end
    end

    // The bench only hands exponent sources within minus one to one.
    // Outside a request the bus is not held, so stale data never looks valid.
    assign o_op_valid = i_req;
    assign o_mem_data = i_req ? i_data : ~last_data;
endmodule : fpsab_issue_model
`default_nettype wire

// [sim/fpsab_unit_monitor.sv]
// Concurrent checks on the ports of the stack arithmetic slice.
`timescale 1ns/1ps
`default_nettype none
module fpsab_unit_monitor
    import fpsab_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire fpsab_op_t i_op,
    input wire fpsab_form_t i_form,
    input wire logic i_fpu_absent_flag,
    input wire logic i_context_swap_flag,
    input wire logic i_low_fp_disable_bit,
    input wire logic o_device_unavailable_fault,
    input wire logic o_disabled_fp_reg_fault,
    input wire logic o_stack_fault_exc,
    input wire logic o_cond_code_one,
    input wire logic [79:0] o_stack_head_reg,
    input wire logic [2:0] o_top,
    input wire logic [7:0] o_tag,
    input wire logic [4:0] o_sticky_flags
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic ok;
    logic [2:0] top_dn;
    logic [2:0] top_up;

    // An operation runs only when no control bit blocks it.
    assign ok = i_op_valid && !i_fpu_absent_flag && !i_context_swap_flag
        && !i_low_fp_disable_bit;
    assign top_dn = o_top - 3'h1;
    assign top_up = o_top + 3'h1;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_UNAVAIL: assert property (i_op_valid && !i_low_fp_disable_bit &&
        (i_fpu_absent_flag || i_context_swap_flag)
        |=> o_device_unavailable_fault) else $error("unavailable fault missing");
    AST_DISABLED: assert property (i_op_valid && i_low_fp_disable_bit
        |=> o_disabled_fp_reg_fault) else $error("disabled fault missing");
    AST_FAULT_HOLD: assert property (i_op_valid && !ok
        |=> $stable(o_top) && $stable(o_tag) && $stable(o_stack_head_reg))
        else $error("faulted op changed stack state");
    AST_ABS_SIGN: assert property (ok && i_op == ABSOLUTE_VALUE_OP
        && o_tag[o_top] |=> o_stack_head_reg ==
        {1'b0, $past(o_stack_head_reg[78:0])}) else $error("abs result wrong");
    AST_ABS_CC: assert property (ok && i_op == ABSOLUTE_VALUE_OP
        |=> !o_cond_code_one) else $error("abs left code one set");
    AST_POP: assert property (ok && i_op == FLOAT_ADD_OP
        && i_form == FORM_NO_OPERAND && o_tag[o_top] && o_tag[top_up]
        |=> o_top == $past(top_up) && !o_tag[$past(o_top)])
        else $error("pop did not advance the stack");
    AST_PUSH: assert property (ok && i_op == DECIMAL_LOAD_PUSH_OP
        && !o_tag[top_dn] |=> o_top == $past(top_dn) && o_tag[o_top])
        else $error("decimal push did not move the stack");
    AST_OVERFLOW: assert property (ok && i_op == DECIMAL_LOAD_PUSH_OP
        && o_tag[top_dn] |=> o_stack_fault_exc && $stable(o_top))
        else $error("overflow not flagged");
    AST_EXP_EMPTY: assert property (ok && i_op == EXP2_MINUS_ONE_OP
        && !o_tag[o_top] |=> o_stack_fault_exc) else $error("exp underflow");
    AST_STICKY: assert property (o_stack_fault_exc
        |-> o_sticky_flags[4]) else $error("stack flag not kept");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    CV_PUSH: cover property (ok && i_op == DECIMAL_LOAD_PUSH_OP);
    CV_POP: cover property (ok && i_op == FLOAT_ADD_POP_OP);
    CV_FAULT: cover property (o_stack_fault_exc ##1 o_stack_fault_exc);
endmodule : fpsab_unit_monitor
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the stack arithmetic slice.
`timescale 1ns/1ps
`default_nettype none
module tb import fpsab_pkg::*;;
    logic sys_clk = 1'b0, rst_n = 1'b0, req = 1'b0;
    logic [79:0] data = 80'h0;
    fpsab_op_t op = FLOAT_ADD_OP;
    fpsab_form_t form = FORM_NO_OPERAND;
    fpsab_fmt_t fmt = FMT_SINGLE;
    logic [2:0] idx = 3'h0;
    logic [1:0] rm = 2'h0;
    logic absent = 1'b0, swap = 1'b0, low = 1'b0, clr = 1'b0;
    logic valid, done, unav, dis, sfault, inval, cc1;
    logic [79:0] mem, head;
    logic [2:0] top;
    logic [7:0] tag;
    logic [4:0] sticky;
    int miscompares = 0, checks = 0;

    always #2 sys_clk = ~sys_clk;

    fpsab_issue_model fpsab_issue_model_inst (.i_sys_clk(sys_clk),
        .i_rst_n(rst_n), .i_req(req), .i_data(data), .o_op_valid(valid),
        .o_mem_data(mem));
    fpsab_unit fpsab_unit_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_op_valid(valid), .i_op(op), .i_form(form), .i_sti_idx(idx),
        .i_mem_data(mem), .i_mem_fmt(fmt), .i_round_mode(rm),
        .i_fpu_absent_flag(absent), .i_context_swap_flag(swap),
        .i_low_fp_disable_bit(low), .i_clear_flags(clr), .o_done(done),
        .o_device_unavailable_fault(unav), .o_disabled_fp_reg_fault(dis),
        .o_stack_fault_exc(sfault), .o_invalid_operand_exc(inval),
        .o_cond_code_one(cc1), .o_stack_head_reg(head), .o_top(top),
        .o_tag(tag), .o_sticky_flags(sticky));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [79:0] got, input logic [79:0] exp,
            input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // One request; the answer is registered on the taking edge and read 1 ns after it.
    task automatic do_op(input fpsab_op_t o,
            input fpsab_form_t f = FORM_NO_OPERAND,
            input logic [2:0] x = 3'h0, input logic [79:0] d = 80'h0,
            input fpsab_fmt_t m = FMT_SINGLE);
        @(posedge sys_clk);
        req <= 1'b1;
        op <= o;
        form <= f;
        idx <= x;
        data <= d;
        fmt <= m;
        @(posedge sys_clk);
        req <= 1'b0;
        #1;
        chk({79'h0, done}, 80'h1, "done");
    endtask : do_op

    task automatic push(input logic [79:0] d, input logic [79:0] exp);
        do_op(DECIMAL_LOAD_PUSH_OP, FORM_NO_OPERAND, 3'h0, d);
        chk(head, exp, "pushed head");
    endtask : push

    task automatic add(input fpsab_form_t f, input logic [79:0] d,
            input fpsab_fmt_t m, input logic [79:0] exp);
        do_op(FLOAT_ADD_OP, f, 3'h0, d, m);
        chk(head, exp, "sum");
    endtask : add

    // ------------------------------------------------------------------
    // Watchdog: the tests need about 70 cycles.
    // ------------------------------------------------------------------
    initial begin
        #20000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({69'h0, top, tag}, 80'h0, "reset stack");
        do_op(ABSOLUTE_VALUE_OP);
        chk({76'h0, sfault, inval, cc1, 1'b0}, 80'hC, "abs empty");
        chk(80'(sticky), 80'h18, "sticky");
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        #1;
        chk({75'h0, sticky}, 80'h0, "cleared");
        $display("test underflow done");
        push(80'h5, 80'h4001_A000_0000_0000_0000);
        push(80'h3, 80'h4000_C000_0000_0000_0000);
        chk({69'h0, top, tag}, 80'h6C0, "two pushes");
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            absent <= (k == 0);
            swap <= (k == 1);
            low <= (k == 2);
            do_op(DECIMAL_LOAD_PUSH_OP, FORM_NO_OPERAND, 3'h0, 80'h1);
            chk(80'(unav), 80'(k != 2), "unavailable");
            chk(80'(dis), 80'(k == 2), "disabled");
            chk({69'h0, top, tag}, 80'h6C0, "held stack");
        end
        @(posedge sys_clk);
        low <= 1'b0;
        $display("test faults done");
        do_op(INTEGER_SOURCE_ADD_OP, FORM_MEMORY, 3'h0, 80'hFFFD, FMT_INT16);
        chk(head, 80'h0, "cancel plus");
        do_op(INTEGER_SOURCE_ADD_OP, FORM_MEMORY, 3'h0, 80'h3, FMT_INT32);
        chk(head, 80'h4000_C000_0000_0000_0000, "int32 add");
        @(posedge sys_clk);
        rm <= RC_DOWN;
        do_op(INTEGER_SOURCE_ADD_OP, FORM_MEMORY, 3'h0, 80'hFFFD, FMT_INT16);
        chk(head, 80'h8000_0000_0000_0000_0000, "cancel down");
        @(posedge sys_clk);
        rm <= 2'h0;
        add(FORM_NO_OPERAND, 80'h0, FMT_SINGLE, 80'h4001_A000_0000_0000_0000);
        chk({69'h0, top, tag}, 80'h780, "pop form");
        add(FORM_HEAD_DEST, 80'h0, FMT_SINGLE, 80'h4002_A000_0000_0000_0000);
        add(FORM_INDEXED_DEST, 80'h0, FMT_SINGLE, 80'h4003_A000_0000_0000_0000);
        add(FORM_MEMORY, 80'h3FF0_0000_0000_0000, FMT_DOUBLE,
            80'h4003_A800_0000_0000_0000);
        add(FORM_MEMORY, 80'h7F80_0000, FMT_SINGLE, 80'h7FFF_8000_0000_0000_0000);
        add(FORM_MEMORY, 80'h7F80_0000, FMT_SINGLE, 80'h7FFF_8000_0000_0000_0000);
        chk({79'h0, inval}, 80'h0, "like infinities");
        add(FORM_MEMORY, 80'hFF80_0000, FMT_SINGLE, QNAN_INDEFINITE);
        chk({79'h0, inval}, 80'h1, "unlike infinities");
        $display("test add done");
        push(80'h0, 80'h0);
        do_op(EXP2_MINUS_ONE_OP);
        chk({78'h0, sfault, head == 80'h0}, 80'h1, "exp of zero");
        push(80'h8000_0000_0000_0000_0003, 80'hC000_C000_0000_0000_0000);
        do_op(ABSOLUTE_VALUE_OP);
        chk(head, 80'h4000_C000_0000_0000_0000, "abs");
        chk({79'h0, cc1}, 80'h0, "abs code");
        do_op(FLOAT_ADD_POP_OP, FORM_NO_OPERAND, 3'h1);
        chk(head, 80'h4000_C000_0000_0000_0000, "pop sum");
        chk({69'h0, top, tag}, 80'h6C0, "pop stack");
        $display("test exp abs pop done");
        for (int k = 0; k < 6; k++) begin
            push(80'h1, 80'h3FFF_8000_0000_0000_0000);
        end
        do_op(DECIMAL_LOAD_PUSH_OP, FORM_NO_OPERAND, 3'h0, 80'h2);
        chk({78'h0, sfault, cc1}, 80'h3, "overflow");
        chk({69'h0, top, tag}, 80'h0FF, "full stack");
        $display("test overflow done");
        report_and_stop();
    end
endmodule : tb

bind fpsab_unit fpsab_unit_monitor fpsab_unit_monitor_inst (
    .i_sys_clk, .i_rst_n, .i_op_valid, .i_op, .i_form, .i_fpu_absent_flag,
    .i_context_swap_flag, .i_low_fp_disable_bit, .o_device_unavailable_fault,
    .o_disabled_fp_reg_fault, .o_stack_fault_exc, .o_cond_code_one,
    .o_stack_head_reg, .o_top, .o_tag, .o_sticky_flags);
`default_nettype wire
